/* File: core/dsl_regs.svh */
// opcode patterns, field positions and byte counts of the opcode decoder
`ifndef DSL_REGS_SVH
`define DSL_REGS_SVH
`define DSL_MASK_W       8'hFE
`define DSL_MASK_DW      8'hFC
`define DSL_OPC_UNARY    8'hF6
`define DSL_OPC_BCD_DIV  8'hD5
`define DSL_OPC_BCD_MUL  8'hD4
`define DSL_OPC_BCD_BASE 8'h0A
`define DSL_OPC_SEXT     8'h98
`define DSL_OPC_SH_ONE   8'hD0
`define DSL_OPC_SH_REG   8'hD2
`define DSL_OPC_SH_IMM   8'hC0
`define DSL_OPC_ESC      8'h0F
`define DSL_OPC_DL_IMM   8'hA4
`define DSL_OPC_DL_REG   8'hA5
`define DSL_OPC_DR_IMM   8'hAC
`define DSL_OPC_DR_REG   8'hAD
`define DSL_OPC_AND_RM   8'h20
`define DSL_OPC_OR_RM    8'h08
`define DSL_OPC_IMM_GRP  8'h80
`define DSL_OPC_AND_ACC  8'h24
`define DSL_OPC_OR_ACC   8'h0C
`define DSL_OPC_TEST_RM  8'h84
`define DSL_OPC_TEST_ACC 8'hA8
`define DSL_BIT_W        0
`define DSL_BIT_D        1
`define DSL_BIT_S        1
`define DSL_FLD_MOD      7:6
`define DSL_FLD_REG      5:3
`define DSL_FLD_RM       2:0
`define DSL_SK_ROL       3'h0
`define DSL_SK_ROR       3'h1
`define DSL_SK_RCL       3'h2
`define DSL_SK_RCR       3'h3
`define DSL_SK_SHL       3'h4
`define DSL_SK_SHR       3'h5
`define DSL_SK_RSVD      3'h6
`define DSL_SK_SAR       3'h7
`define DSL_UN_TEST      3'h0
`define DSL_UN_DIV       3'h7
`define DSL_IG_AND       3'h4
`define DSL_IG_OR        3'h1
`define DSL_MOD_MEM0     2'h0
`define DSL_MOD_MEM8     2'h1
`define DSL_MOD_REG      2'h3
`define DSL_RM_SIB       3'h4
`define DSL_RM_DISP32    3'h5
`define DSL_RM_DISP16    3'h6
`define DSL_SIB_NOBASE   3'h5
`define DSL_BYTES_NONE   3'h0
`define DSL_BYTES_ONE    3'h1
`define DSL_BYTES_16     3'h2
`define DSL_BYTES_32     3'h4
`define DSL_RST_BYTE     8'h00
`endif

/* File: core/dsl_pkg.sv */
// types shared by the opcode decoder
package dsl_pkg;
  typedef enum logic [4:0] {
    op_none, signed_quotient_op, unpacked_bcd_pre_divide, unpacked_bcd_post_multiply,
    sign_extend_byte_op, rotate_left_op, rotate_right_op, rotate_left_via_carry,
    rotate_right_via_carry, shift_left_op, logical_right_shift, arithmetic_right_shift,
    double_left_shift, double_right_shift, and_op, or_op, test_op
  } dsl_op_t;
  typedef enum logic [1:0] {cnt_none, cnt_one, cnt_reg, cnt_imm} dsl_cnt_t;
  typedef enum logic [1:0] {grp_none, grp_shift, grp_unary, grp_imm} dsl_grp_t;
  typedef enum logic [2:0] {
    st_opcode, st_escape, st_second, st_modrm, st_sib, st_disp, st_imm
  } dsl_st_t;
endpackage

/* File: core/dsl_imm_collect.sv */
// gathers immediate bytes little-endian, optional byte sign extension
`timescale 1ns/1ps
`include "dsl_regs.svh"
module dsl_imm_collect (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        clear,
  input  wire logic        take,
  input  wire logic [7:0]  byte_in,
  input  wire logic        sext,
  output logic      [2:0]  got,
  output logic      [31:0] value
);
  logic [31:0] acc;
  logic [31:0] next_acc;

  assign next_acc = acc | (32'({24'h000000, byte_in}) << {got, 3'b000});
  // value includes the byte arriving now, so the final byte needs no extra cycle
  assign value = sext ? {{24{byte_in[7]}}, byte_in} : next_acc;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      acc <= 32'h00000000;
      got <= `DSL_BYTES_NONE;
    end else if (clear) begin
      acc <= 32'h00000000;
      got <= `DSL_BYTES_NONE;
    end else if (take) begin
      acc <= next_acc;
      got <= 3'(got + 3'h1);
    end
  end
endmodule // dsl_imm_collect

/* File: core/dsl_decoder.sv */
// byte-serial decoder for divide, adjust, shift and logic opcodes
`timescale 1ns/1ps
`include "dsl_regs.svh"
module dsl_decoder (
  input  wire logic               ref_clk,
  input  wire logic               rstn,
  input  wire logic               in_valid,
  input  wire logic [7:0]         in_byte,
  input  wire logic               op_size_32,
  input  wire logic               addr_size_32,
  output logic                    dec_valid,
  output dsl_pkg::dsl_op_t        dec_op,
  output dsl_pkg::dsl_cnt_t       dec_count_src,
  output logic      [7:0]         dec_opcode,
  output logic      [7:0]         dec_modrm,
  output logic                    dec_has_modrm,
  output logic                    dec_full_width,
  output logic                    dec_dir,
  output logic                    dec_writes_result,
  output logic      [2:0]         dec_imm_bytes,
  output logic                    dec_imm_sext,
  output logic      [31:0]        dec_imm,
  output logic      [3:0]         dec_len,
  output logic                    dec_reserved,
  output logic                    dec_unsupported
);
  dsl_pkg::dsl_st_t  st, next_st;
  dsl_pkg::dsl_op_t  op, next_op;
  dsl_pkg::dsl_cnt_t cnt, next_cnt;
  dsl_pkg::dsl_grp_t grp, next_grp;
  logic [7:0]  opc, next_opc;
  logic [7:0]  modrm, next_modrm;
  logic        full, next_full;
  logic        dir, next_dir;
  logic        wr, next_wr;
  logic        hm, next_hm;
  logic        sext, next_sext;
  logic        rsvd, next_rsvd;
  logic        unsup, next_unsup;
  logic        s32, next_s32;
  logic        a32, next_a32;
  logic [2:0]  imm_n, next_imm_n;
  logic [2:0]  disp, next_disp;
  logic [3:0]  len, next_len;
  logic [2:0]  imm_got;
  logic [31:0] imm_val;

  function automatic logic opm(input logic [7:0] b, input logic [7:0] m, input logic [7:0] v);
    return (b & m) == v;
  endfunction

  function automatic logic [2:0] imm_for_w(input logic w, input logic sz32);
    if (!w) return `DSL_BYTES_ONE;
    return sz32 ? `DSL_BYTES_32 : `DSL_BYTES_16;
  endfunction

  function automatic logic [2:0] disp_bytes(input logic [7:0] m, input logic ad32);
    logic [1:0] md;
    md = m[`DSL_FLD_MOD];
    if (md == `DSL_MOD_REG) return `DSL_BYTES_NONE;
    if (md == `DSL_MOD_MEM8) return `DSL_BYTES_ONE;
    if (md == `DSL_MOD_MEM0) begin
      if (ad32) return (m[`DSL_FLD_RM] == `DSL_RM_DISP32) ? `DSL_BYTES_32 : `DSL_BYTES_NONE;
      return (m[`DSL_FLD_RM] == `DSL_RM_DISP16) ? `DSL_BYTES_16 : `DSL_BYTES_NONE;
    end
    return ad32 ? `DSL_BYTES_32 : `DSL_BYTES_16;
  endfunction

  function automatic dsl_pkg::dsl_st_t after_addr(input logic [2:0] d, input logic [2:0] i);
    if (d != `DSL_BYTES_NONE) return dsl_pkg::st_disp;
    if (i != `DSL_BYTES_NONE) return dsl_pkg::st_imm;
    return dsl_pkg::st_opcode;
  endfunction

  function automatic dsl_pkg::dsl_op_t shift_op(input logic [2:0] k);
    case (k)
      `DSL_SK_ROL: return dsl_pkg::rotate_left_op;
      `DSL_SK_ROR: return dsl_pkg::rotate_right_op;
      `DSL_SK_RCL: return dsl_pkg::rotate_left_via_carry;
      `DSL_SK_RCR: return dsl_pkg::rotate_right_via_carry;
      `DSL_SK_SHL: return dsl_pkg::shift_left_op;
      `DSL_SK_SHR: return dsl_pkg::logical_right_shift;
      `DSL_SK_SAR: return dsl_pkg::arithmetic_right_shift;
      default:     return dsl_pkg::op_none;
    endcase
  endfunction

  // first-byte classification
  wire is_sext_op  = in_byte == `DSL_OPC_SEXT;
  wire is_bcd_div  = in_byte == `DSL_OPC_BCD_DIV;
  wire is_bcd_mul  = in_byte == `DSL_OPC_BCD_MUL;
  wire is_esc      = in_byte == `DSL_OPC_ESC;
  wire is_sh_one   = opm(in_byte, `DSL_MASK_W, `DSL_OPC_SH_ONE);
  wire is_sh_reg   = opm(in_byte, `DSL_MASK_W, `DSL_OPC_SH_REG);
  wire is_sh_imm   = opm(in_byte, `DSL_MASK_W, `DSL_OPC_SH_IMM);
  wire is_unary    = opm(in_byte, `DSL_MASK_W, `DSL_OPC_UNARY);
  wire is_imm_grp  = opm(in_byte, `DSL_MASK_DW, `DSL_OPC_IMM_GRP);
  wire is_and_rm   = opm(in_byte, `DSL_MASK_DW, `DSL_OPC_AND_RM);
  wire is_or_rm    = opm(in_byte, `DSL_MASK_DW, `DSL_OPC_OR_RM);
  wire is_test_rm  = opm(in_byte, `DSL_MASK_W, `DSL_OPC_TEST_RM);
  wire is_and_acc  = opm(in_byte, `DSL_MASK_W, `DSL_OPC_AND_ACC);
  wire is_or_acc   = opm(in_byte, `DSL_MASK_W, `DSL_OPC_OR_ACC);
  wire is_test_acc = opm(in_byte, `DSL_MASK_W, `DSL_OPC_TEST_ACC);
  wire is_shift    = is_sh_one | is_sh_reg | is_sh_imm;
  wire is_acc_form = is_and_acc | is_or_acc | is_test_acc;
  wire w_bit       = in_byte[`DSL_BIT_W];
  // modrm and sib decode
  wire [2:0] fld      = in_byte[`DSL_FLD_REG];
  wire [2:0] m_disp   = disp_bytes(in_byte, a32);
  wire       m_sib    = a32 && in_byte[`DSL_FLD_MOD] != `DSL_MOD_REG && in_byte[`DSL_FLD_RM] == `DSL_RM_SIB;
  wire       no_base  = modrm[`DSL_FLD_MOD] == `DSL_MOD_MEM0 && in_byte[`DSL_FLD_RM] == `DSL_SIB_NOBASE;
  wire [2:0] sib_disp = no_base ? `DSL_BYTES_32 : disp;
  wire       imm_last = 3'(imm_got + 3'h1) == imm_n;
  wire       fin      = in_valid && next_st == dsl_pkg::st_opcode;

  always_comb begin
    next_st    = st;
    next_op    = op;
    next_cnt   = cnt;
    next_grp   = grp;
    next_opc   = opc;
    next_modrm = modrm;
    next_full  = full;
    next_dir   = dir;
    next_wr    = wr;
    next_hm    = hm;
    next_sext  = sext;
    next_rsvd  = rsvd;
    next_unsup = unsup;
    next_s32   = s32;
    next_a32   = a32;
    next_imm_n = imm_n;
    next_disp  = disp;
    next_len   = in_valid ? 4'(len + 4'h1) : len;
    case (st)
      dsl_pkg::st_opcode: if (in_valid) begin
        next_opc   = in_byte;
        next_s32   = op_size_32;
        next_a32   = addr_size_32;
        next_len   = 4'h1;
        next_op    = dsl_pkg::op_none;
        next_cnt   = dsl_pkg::cnt_none;
        next_grp   = dsl_pkg::grp_none;
        next_full  = w_bit;
        next_dir   = 1'b0;
        next_wr    = 1'b1;
        next_hm    = 1'b0;
        next_modrm = `DSL_RST_BYTE;
        next_imm_n = `DSL_BYTES_NONE;
        next_sext  = 1'b0;
        next_disp  = `DSL_BYTES_NONE;
        next_rsvd  = 1'b0;
        next_unsup = 1'b0;
        if (is_sext_op) begin
          next_op = dsl_pkg::sign_extend_byte_op;
        end else if (is_bcd_div) begin
          next_op = dsl_pkg::unpacked_bcd_pre_divide;
          next_st = dsl_pkg::st_second;
        end else if (is_bcd_mul) begin
          next_op = dsl_pkg::unpacked_bcd_post_multiply;
          next_st = dsl_pkg::st_second;
        end else if (is_esc) begin
          next_st = dsl_pkg::st_escape;
        end else if (is_shift) begin
          next_grp   = dsl_pkg::grp_shift;
          next_hm    = 1'b1;
          next_cnt   = is_sh_one ? dsl_pkg::cnt_one : is_sh_reg ? dsl_pkg::cnt_reg : dsl_pkg::cnt_imm;
          next_imm_n = is_sh_imm ? `DSL_BYTES_ONE : `DSL_BYTES_NONE;
          next_st    = dsl_pkg::st_modrm;
        end else if (is_unary) begin
          next_grp = dsl_pkg::grp_unary;
          next_hm  = 1'b1;
          next_st  = dsl_pkg::st_modrm;
        end else if (is_imm_grp) begin
          next_grp   = dsl_pkg::grp_imm;
          next_hm    = 1'b1;
          next_sext  = in_byte[`DSL_BIT_S] & w_bit;
          next_imm_n = in_byte[`DSL_BIT_S] ? `DSL_BYTES_ONE : imm_for_w(w_bit, op_size_32);
          next_st    = dsl_pkg::st_modrm;
        end else if (is_and_rm | is_or_rm) begin
          next_op  = is_and_rm ? dsl_pkg::and_op : dsl_pkg::or_op;
          next_dir = in_byte[`DSL_BIT_D];
          next_hm  = 1'b1;
          next_st  = dsl_pkg::st_modrm;
        end else if (is_test_rm) begin
          next_op = dsl_pkg::test_op;
          next_wr = 1'b0;
          next_hm = 1'b1;
          next_st = dsl_pkg::st_modrm;
        end else if (is_acc_form) begin
          next_op    = is_and_acc ? dsl_pkg::and_op : is_or_acc ? dsl_pkg::or_op : dsl_pkg::test_op;
          next_wr    = !is_test_acc;
          next_imm_n = imm_for_w(w_bit, op_size_32);
          next_st    = dsl_pkg::st_imm;
        end else begin
          next_unsup = 1'b1;
        end
      end
      dsl_pkg::st_second: if (in_valid) begin
        if (in_byte != `DSL_OPC_BCD_BASE) begin
          next_op    = dsl_pkg::op_none;
          next_unsup = 1'b1;
        end
        next_st = dsl_pkg::st_opcode;
      end
      dsl_pkg::st_escape: if (in_valid) begin
        next_full = 1'b1;
        next_hm   = 1'b1;
        next_st   = dsl_pkg::st_modrm;
        case (in_byte)
          `DSL_OPC_DL_IMM: begin
            next_op    = dsl_pkg::double_left_shift;
            next_cnt   = dsl_pkg::cnt_imm;
            next_imm_n = `DSL_BYTES_ONE;
          end
          `DSL_OPC_DL_REG: begin
            next_op  = dsl_pkg::double_left_shift;
            next_cnt = dsl_pkg::cnt_reg;
          end
          `DSL_OPC_DR_IMM: begin
            next_op    = dsl_pkg::double_right_shift;
            next_cnt   = dsl_pkg::cnt_imm;
            next_imm_n = `DSL_BYTES_ONE;
          end
          `DSL_OPC_DR_REG: begin
            next_op  = dsl_pkg::double_right_shift;
            next_cnt = dsl_pkg::cnt_reg;
          end
          default: begin
            next_hm    = 1'b0;
            next_unsup = 1'b1;
            next_st    = dsl_pkg::st_opcode;
          end
        endcase
      end
      dsl_pkg::st_modrm: if (in_valid) begin
        next_modrm = in_byte;
        case (grp)
          dsl_pkg::grp_shift: begin
            next_op   = shift_op(fld);
            next_rsvd = fld == `DSL_SK_RSVD;
          end
          dsl_pkg::grp_unary: begin
            if (fld == `DSL_UN_DIV) begin
              next_op = dsl_pkg::signed_quotient_op;
            end else if (fld == `DSL_UN_TEST) begin
              next_op    = dsl_pkg::test_op;
              next_wr    = 1'b0;
              next_imm_n = imm_for_w(opc[`DSL_BIT_W], s32);
            end else begin
              next_unsup = 1'b1;
            end
          end
          dsl_pkg::grp_imm: begin
            if (fld == `DSL_IG_AND) next_op = dsl_pkg::and_op;
            else if (fld == `DSL_IG_OR) next_op = dsl_pkg::or_op;
            else next_unsup = 1'b1;
          end
          default: ;
        endcase
        // addressing bytes come first so the trailing immediate stays aligned
        next_disp = m_disp;
        next_st   = m_sib ? dsl_pkg::st_sib : after_addr(m_disp, next_imm_n);
      end
      dsl_pkg::st_sib: if (in_valid) begin
        next_disp = sib_disp;
        next_st   = after_addr(sib_disp, imm_n);
      end
      dsl_pkg::st_disp: if (in_valid) begin
        next_disp = 3'(disp - 3'h1);
        if (disp == `DSL_BYTES_ONE) next_st = after_addr(`DSL_BYTES_NONE, imm_n);
      end
      dsl_pkg::st_imm: if (in_valid) begin
        if (imm_last) next_st = dsl_pkg::st_opcode;
      end
      default: next_st = dsl_pkg::st_opcode;
    endcase
  end

  dsl_imm_collect u_imm (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .clear   (st == dsl_pkg::st_opcode),
    .take    (in_valid && st == dsl_pkg::st_imm),
    .byte_in (in_byte),
    .sext    (sext),
    .got     (imm_got),
    .value   (imm_val)
  );

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st    <= dsl_pkg::st_opcode;
      op    <= dsl_pkg::op_none;
      cnt   <= dsl_pkg::cnt_none;
      grp   <= dsl_pkg::grp_none;
      opc   <= `DSL_RST_BYTE;
      modrm <= `DSL_RST_BYTE;
      {full, dir, wr, hm, sext, rsvd, unsup, s32, a32} <= 9'h000;
      imm_n <= `DSL_BYTES_NONE;
      disp  <= `DSL_BYTES_NONE;
      len   <= 4'h0;
    end else begin
      st    <= next_st;
      op    <= next_op;
      cnt   <= next_cnt;
      grp   <= next_grp;
      opc   <= next_opc;
      modrm <= next_modrm;
      {full, dir, wr, hm, sext, rsvd, unsup, s32, a32} <=
        {next_full, next_dir, next_wr, next_hm, next_sext, next_rsvd, next_unsup, next_s32, next_a32};
      imm_n <= next_imm_n;
      disp  <= next_disp;
      len   <= next_len;
    end
  end

  // results are held until the next instruction completes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dec_valid         <= 1'b0;
      dec_op            <= dsl_pkg::op_none;
      dec_count_src     <= dsl_pkg::cnt_none;
      dec_opcode        <= `DSL_RST_BYTE;
      dec_modrm         <= `DSL_RST_BYTE;
      {dec_has_modrm, dec_full_width, dec_dir, dec_writes_result} <= 4'h0;
      {dec_imm_sext, dec_reserved, dec_unsupported} <= 3'h0;
      dec_imm_bytes     <= `DSL_BYTES_NONE;
      dec_imm           <= 32'h00000000;
      dec_len           <= 4'h0;
    end else begin
      dec_valid <= fin;
      if (fin) begin
        dec_op            <= next_op;
        dec_count_src     <= next_cnt;
        dec_opcode        <= next_opc;
        dec_modrm         <= next_modrm;
        dec_has_modrm     <= next_hm;
        dec_full_width    <= next_full;
        dec_dir           <= next_dir;
        dec_writes_result <= next_wr;
        dec_imm_sext      <= next_sext;
        dec_reserved      <= next_rsvd;
        dec_unsupported   <= next_unsup;
        dec_imm_bytes     <= next_imm_n;
        dec_imm           <= (next_imm_n == `DSL_BYTES_NONE) ? 32'h00000000 : imm_val;
        dec_len           <= next_len;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_first(logic [7:0] v);
    st == dsl_pkg::st_opcode && in_valid && in_byte == v;
  endsequence
  sequence s_next(logic [7:0] v);
    in_valid && in_byte == v;
  endsequence

  chk_pre_divide_pair: assert property (
    s_first(`DSL_OPC_BCD_DIV) ##1 s_next(`DSL_OPC_BCD_BASE) |=>
      dec_valid && dec_op == dsl_pkg::unpacked_bcd_pre_divide && dec_len == 4'h2)
    else $error("pre-divide adjust pair not decoded");
  chk_post_multiply_pair: assert property (
    s_first(`DSL_OPC_BCD_MUL) ##1 s_next(`DSL_OPC_BCD_BASE) |=>
      dec_valid && dec_op == dsl_pkg::unpacked_bcd_post_multiply && !dec_unsupported)
    else $error("post-multiply adjust pair not decoded");
  chk_sign_extend_single: assert property (
    s_first(`DSL_OPC_SEXT) |=> dec_valid && dec_op == dsl_pkg::sign_extend_byte_op
      && !dec_has_modrm && dec_len == 4'h1 && dec_imm_bytes == `DSL_BYTES_NONE)
    else $error("sign extend not a one byte instruction");
  chk_divide_field: assert property (
    dec_valid && dec_op == dsl_pkg::signed_quotient_op |->
      dec_modrm[`DSL_FLD_REG] == `DSL_UN_DIV && opm(dec_opcode, `DSL_MASK_W, `DSL_OPC_UNARY)
      && dec_imm_bytes == `DSL_BYTES_NONE)
    else $error("signed divide from wrong encoding");
  chk_flags_only_and: assert property (
    dec_valid && dec_op == dsl_pkg::test_op |-> !dec_writes_result)
    else $error("flags-only AND writes a result");
  chk_unary_test_form: assert property (
    dec_valid && opm(dec_opcode, `DSL_MASK_W, `DSL_OPC_UNARY) && dec_modrm[`DSL_FLD_REG] == `DSL_UN_TEST
      |-> dec_op == dsl_pkg::test_op && dec_imm_bytes != `DSL_BYTES_NONE)
    else $error("immediate test form misdecoded");
  chk_shift_count_byte: assert property (
    dec_valid && dec_count_src == dsl_pkg::cnt_imm |->
      dec_imm_bytes == `DSL_BYTES_ONE && dec_imm[31:8] == 24'h000000)
    else $error("immediate shift count not one byte");
  chk_reserved_shift: assert property (
    dec_valid && dec_reserved |-> dec_op == dsl_pkg::op_none && dec_modrm[`DSL_FLD_REG] == `DSL_SK_RSVD)
    else $error("reserved shift kind executed");
  chk_imm_sign_ext: assert property (
    dec_valid && dec_imm_sext |-> dec_imm_bytes == `DSL_BYTES_ONE && dec_imm[31:8] == {24{dec_imm[7]}})
    else $error("sign-extended immediate wrong");
  chk_width_bit: assert property (
    dec_valid && !dec_unsupported && (dec_op == dsl_pkg::and_op || dec_op == dsl_pkg::or_op
      || dec_op == dsl_pkg::test_op) |-> dec_full_width == dec_opcode[`DSL_BIT_W])
    else $error("operand width not from w bit");
endmodule // dsl_decoder

/* File: verif/dsl_fetch_model.sv */
// fetch stage model: hands instruction bytes to the decoder, stalls at random
`timescale 1ns/1ps
module dsl_fetch_model (
  input  wire logic       ref_clk,
  output logic            in_valid,
  output logic      [7:0] in_byte
);
  initial begin
    in_valid = 1'h0;
    in_byte  = 8'h00;
  end
  // stalled lane is inverted so a stale byte never reads as fresh data
  task automatic put(input logic [7:0] b, input int gap);
    repeat (gap) begin
      @(negedge ref_clk);
      in_valid = 1'h0;
      in_byte  = ~in_byte;
    end
    @(negedge ref_clk);
    in_valid = 1'h1;
    in_byte  = b;
  endtask
  task automatic idle();
    @(negedge ref_clk);
    in_valid = 1'h0;
    in_byte  = ~in_byte;
  endtask
endmodule // dsl_fetch_model

/* File: verif/tb_top.sv */
// self-checking bench for the divide, shift and logic opcode decoder
`timescale 1ns/1ps
module tb_top;
  // ud holds the expected unsupported flag (bit 1) and direction bit (bit 0)
  typedef struct {dsl_pkg::dsl_op_t op; dsl_pkg::dsl_cnt_t cnt; logic [3:0] len; logic [31:0] imm; logic wr;
    logic [1:0] ud;} dsl_exp_t;
  logic                ref_clk, rstn, in_valid, op_size_32, addr_size_32, dec_valid, dec_wr, dec_rsv, dec_dir, dec_uns;
  logic [7:0]          in_byte;
  dsl_pkg::dsl_op_t    dec_op;
  dsl_pkg::dsl_cnt_t   dec_cnt;
  logic [3:0]          dec_len;
  logic [31:0]         dec_imm, v, seed;
  logic [7:0]          bq[$];
  dsl_exp_t            eq[$];
  dsl_exp_t            e;
  int                  err_total, num_checks;
  dsl_pkg::dsl_op_t    kinds[8] = '{dsl_pkg::rotate_left_op, dsl_pkg::rotate_right_op, dsl_pkg::rotate_left_via_carry,
    dsl_pkg::rotate_right_via_carry, dsl_pkg::shift_left_op, dsl_pkg::logical_right_shift, dsl_pkg::op_none,
    dsl_pkg::arithmetic_right_shift};
  dsl_fetch_model fm (.ref_clk(ref_clk), .in_valid(in_valid), .in_byte(in_byte));
  dsl_decoder uut (.ref_clk(ref_clk), .rstn(rstn), .in_valid(in_valid), .in_byte(in_byte), .op_size_32(op_size_32),
    .addr_size_32(addr_size_32), .dec_valid(dec_valid), .dec_op(dec_op), .dec_count_src(dec_cnt), .dec_opcode(),
    .dec_modrm(), .dec_has_modrm(), .dec_full_width(), .dec_dir(dec_dir), .dec_writes_result(dec_wr),
    .dec_imm_bytes(), .dec_imm_sext(), .dec_imm(dec_imm), .dec_len(dec_len), .dec_reserved(dec_rsv),
    .dec_unsupported(dec_uns));
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // note the expectation first, then feed the bytes with random stalls
  task automatic ins(input dsl_pkg::dsl_op_t op, input dsl_pkg::dsl_cnt_t cnt, input logic [31:0] imm, input logic wr,
                     input logic [1:0] ud = 2'h0);
    eq.push_back('{op, cnt, 4'(bq.size()), imm, wr, ud});
    foreach (bq[i]) fm.put(bq[i], int'(rnd() & 32'h1));
    $display("test %0s done", op.name());
    bq.delete();
  endtask
  task automatic imm4(input logic [31:0] x);
    for (int i = 0; i < 4; i++) bq.push_back(x[8*i +: 8]);
  endtask
  always @(negedge ref_clk) begin
    if (dec_valid === 1'h1) begin
      if (eq.size() == 0) begin
        check("unexpected result", 32'h1, 32'h0);
      end else begin
        e = eq.pop_front();
        check("op", 32'(dec_op), 32'(e.op));
        check("reserved", 32'(dec_rsv), 32'(e.op == dsl_pkg::op_none && !e.ud[1]));
        check("unsupported", 32'(dec_uns), 32'(e.ud[1]));
        check("direction", 32'(dec_dir), 32'(e.ud[0]));
        if (e.op != dsl_pkg::op_none) check("count source", 32'(dec_cnt), 32'(e.cnt));
        check("length", 32'(dec_len), 32'(e.len));
        check("immediate", dec_imm, e.imm);
        check("writes", 32'(dec_wr), 32'(e.wr));
      end
    end
  end
  initial begin
    #200000;
    err_total++;
    close_out();
  end
  initial begin
    seed = 32'hEBD6D804;
    rstn = 1'h0;
    op_size_32 = 1'h1;
    addr_size_32 = 1'h0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk) rstn = 1'h1;
    v = rnd();
    bq = '{8'hF7, 8'hF8}; ins(dsl_pkg::signed_quotient_op, dsl_pkg::cnt_none, 32'h0, 1'h1);
    bq = '{8'hF7, 8'hD8}; ins(dsl_pkg::op_none, dsl_pkg::cnt_none, 32'h0, 1'h1, 2'h2);
    bq = '{8'hD5, 8'h0A}; ins(dsl_pkg::unpacked_bcd_pre_divide, dsl_pkg::cnt_none, 32'h0, 1'h1);
    bq = '{8'hD4, 8'h0A}; ins(dsl_pkg::unpacked_bcd_post_multiply, dsl_pkg::cnt_none, 32'h0, 1'h1);
    bq = '{8'h98}; ins(dsl_pkg::sign_extend_byte_op, dsl_pkg::cnt_none, 32'h0, 1'h1);
    for (int k = 0; k < 8; k++) begin
      bq = '{8'hD0, {2'h3, 3'(k), 3'h0}}; ins(kinds[k], dsl_pkg::cnt_one, 32'h0, 1'h1);
    end
    bq = '{8'hD3, 8'hC8}; ins(dsl_pkg::rotate_right_op, dsl_pkg::cnt_reg, 32'h0, 1'h1);
    bq = '{8'hC1, 8'hE0, v[7:0]}; ins(dsl_pkg::shift_left_op, dsl_pkg::cnt_imm, {24'h0, v[7:0]}, 1'h1);
    bq = '{8'h0F, 8'hA4, 8'hC0, v[7:0]}; ins(dsl_pkg::double_left_shift, dsl_pkg::cnt_imm, {24'h0, v[7:0]}, 1'h1);
    bq = '{8'h0F, 8'hA5, 8'hC0}; ins(dsl_pkg::double_left_shift, dsl_pkg::cnt_reg, 32'h0, 1'h1);
    bq = '{8'h0F, 8'hAC, 8'hC0, v[7:0]}; ins(dsl_pkg::double_right_shift, dsl_pkg::cnt_imm, {24'h0, v[7:0]}, 1'h1);
    bq = '{8'h0F, 8'hAD, 8'hC0}; ins(dsl_pkg::double_right_shift, dsl_pkg::cnt_reg, 32'h0, 1'h1);
    bq = '{8'h20, 8'h46, v[7:0]}; ins(dsl_pkg::and_op, dsl_pkg::cnt_none, 32'h0, 1'h1);
    bq = '{8'h0B, 8'hC0}; ins(dsl_pkg::or_op, dsl_pkg::cnt_none, 32'h0, 1'h1, 2'h1);
    bq = '{8'h81, 8'hE0}; imm4(v); ins(dsl_pkg::and_op, dsl_pkg::cnt_none, v, 1'h1);
    bq = '{8'h83, 8'hC8, 8'hF0}; ins(dsl_pkg::or_op, dsl_pkg::cnt_none, 32'hFFFFFFF0, 1'h1);
    bq = '{8'h25}; imm4(v); ins(dsl_pkg::and_op, dsl_pkg::cnt_none, v, 1'h1);
    bq = '{8'h0C, v[7:0]}; ins(dsl_pkg::or_op, dsl_pkg::cnt_none, {24'h0, v[7:0]}, 1'h1);
    bq = '{8'h85, 8'hC0}; ins(dsl_pkg::test_op, dsl_pkg::cnt_none, 32'h0, 1'h0);
    bq = '{8'hF6, 8'hC0, v[7:0]}; ins(dsl_pkg::test_op, dsl_pkg::cnt_none, {24'h0, v[7:0]}, 1'h0);
    // 32-bit addressing: sib with no base pulls a 4-byte displacement before the immediate
    addr_size_32 = 1'h1;
    bq = '{8'h81, 8'h24, 8'h25}; imm4(v); imm4(v); ins(dsl_pkg::and_op, dsl_pkg::cnt_none, v, 1'h1);
    op_size_32 = 1'h0;
    bq = '{8'hA9, v[7:0], v[15:8]}; ins(dsl_pkg::test_op, dsl_pkg::cnt_none, {16'h0, v[15:0]}, 1'h0);
    fm.idle();
    repeat (4) @(negedge ref_clk);
    check("pending results", 32'(eq.size()), 32'h0);
    close_out();
  end
endmodule // tb_top
